// *** audio_sync_led_pwm_ctrl.sv ***
// Write-only two-wire target, mode logic and band randomiser for three LED channels
// How it works
// - Answer only address 111101X0, X taken from the address select pin.
// - Each data line bit is taken on a rising serial clock edge.
// - Data falling while clock high starts a transfer and address compare.
// - On a matching address, pull data low through the ninth clock pulse.
// - Each data byte arrives MSB first and is acknowledged in pulse nine.
// - Further bytes may follow in one transfer, each acknowledged.
// - Data rising while clock high ends the transfer; idle line is high.
// - Pattern select clear gives audio mode, duty from band levels.
// - Randomiser off: low band to output one, mid two, high three.
// - Each output's duty rises monotonically with its band level.
// - Band shuffle enable bit turns the randomiser on and off.
// - Randomiser has no effect in direct pattern mode.
// - Active randomiser picks a new mapping every 3.2 seconds.
// - Pattern select set gives direct mode, force bits alone drive outputs.
// - In direct mode each force bit gives full duty when set, zero when clear.
// - Two-bit rate field picks one of four PWM rates for all outputs.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "led_pwm_consts.svh"
module audio_sync_led_pwm_ctrl #(
	parameter logic [15:0] PWM_DIV_F1     = 16'(`PWM_DIV(`PWM_F1_HZ)),
	parameter logic [15:0] PWM_DIV_F2     = 16'(`PWM_DIV(`PWM_F2_HZ)),
	parameter logic [15:0] PWM_DIV_F3     = 16'(`PWM_DIV(`PWM_F3_HZ)),
	parameter logic [27:0] SHUFFLE_CYCLES = 28'(`SHUFFLE_CYCLES)
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Two-wire bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic       addr_sel,
	// Band levels from the audio filters
	input  wire logic [7:0] level_low,
	input  wire logic [7:0] level_mid,
	input  wire logic [7:0] level_high,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	// LED drive
	output logic [2:0]      led_out
);
	// ==========================================================
	// Pin synchronisers
	logic scl_meta, scl_s, scl_d;
	logic sda_meta, sda_s, sda_d;
	logic adr_meta, adr_s;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_meta <= 1'b1;
			scl_s    <= 1'b1;
			scl_d    <= 1'b1;
			sda_meta <= 1'b1;
			sda_s    <= 1'b1;
			sda_d    <= 1'b1;
			adr_meta <= 1'b0;
			adr_s    <= 1'b0;
		end else begin
			scl_meta <= scl_in;
			scl_s    <= scl_meta;
			scl_d    <= scl_s;
			sda_meta <= sda_in;
			sda_s    <= sda_meta;
			sda_d    <= sda_s;
			adr_meta <= addr_sel;
			adr_s    <= adr_meta;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise  = scl_s && !scl_d;
	assign scl_fall  = !scl_s && scl_d;
	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

	// ==========================================================
	// Two-wire target
	led_pwm_pkg::i2c_state_t state;
	logic [7:0] shift;
	logic [7:0] next_byte;
	logic [7:0] own_addr;
	logic [2:0] bit_cnt;
	logic       first_byte;
	logic [7:0] pointer;
	logic       i2c_wr;
	logic [7:0] i2c_idx;
	logic [7:0] i2c_data;

	assign next_byte = {shift[6:0], sda_s};
	assign own_addr  = {`TARGET_ADDR_HI, adr_s, `TARGET_WRITE};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state      <= led_pwm_pkg::st_idle;
			shift      <= '0;
			bit_cnt    <= '0;
			first_byte <= 1'b1;
			pointer    <= '0;
			i2c_wr     <= 1'b0;
			i2c_idx    <= '0;
			i2c_data   <= '0;
			sda_out    <= 1'b0;
			sda_oe_n   <= 1'b1;
		end else begin
			i2c_wr <= 1'b0;
			if (start_det) begin
				state      <= led_pwm_pkg::st_addr;
				bit_cnt    <= '0;
				first_byte <= 1'b1;
				sda_oe_n   <= 1'b1;
			end else if (stop_det) begin
				state    <= led_pwm_pkg::st_idle;
				sda_oe_n <= 1'b1;
			end else begin
				unique case (state)
					led_pwm_pkg::st_idle: begin
						sda_oe_n <= 1'b1;
					end
					led_pwm_pkg::st_addr: begin
						if (scl_rise) begin
							shift   <= next_byte;
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == `BIT_LAST) begin
								// Read direction or foreign address: stay off the bus
								state <= (next_byte == own_addr) ? led_pwm_pkg::st_addr_ack
								                                 : led_pwm_pkg::st_idle;
							end
						end
					end
					led_pwm_pkg::st_addr_ack, led_pwm_pkg::st_data_ack: begin
						// Drive after the eighth pulse falls, release after the ninth
						if (scl_fall && sda_oe_n) begin
							sda_oe_n <= 1'b0;
						end else if (scl_fall) begin
							sda_oe_n <= 1'b1;
							bit_cnt  <= '0;
							state    <= led_pwm_pkg::st_data;
						end
					end
					led_pwm_pkg::st_data: begin
						if (scl_rise) begin
							shift   <= next_byte;
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == `BIT_LAST) begin
								state      <= led_pwm_pkg::st_data_ack;
								first_byte <= 1'b0;
								if (first_byte) begin
									pointer <= next_byte;
								end else begin
									i2c_wr   <= 1'b1;
									i2c_idx  <= pointer;
									i2c_data <= next_byte;
									pointer  <= pointer + 8'h01;
								end
							end
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Control register
	// The register port wins a same-cycle clash with the bus.
	logic [7:0] ctrl;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl <= `CTRL_RESET;
		end else if (reg_wr && reg_addr == `REG_CTRL) begin
			ctrl <= reg_wdata;
		end else if (i2c_wr && i2c_idx == `REG_CTRL) begin
			ctrl <= i2c_data;
		end
	end

	logic       pattern_select;
	logic       band_shuffle_enable;
	logic [2:0] force_out;
	assign pattern_select      = ctrl[`CTRL_PATTERN];
	assign band_shuffle_enable = ctrl[`CTRL_SHUFFLE];
	assign force_out           = ctrl[`CTRL_FORCE_HI:`CTRL_FORCE_LO];

	// ==========================================================
	// Band randomiser
	logic [7:0]              lfsr;
	logic [27:0]             interval;
	logic                    shuffle_tick;
	led_pwm_pkg::map_idx_t   map_idx;
	logic [3:0]              map_sum;
	logic [7:0]              step_ofs;

	assign shuffle_tick = band_shuffle_enable && !pattern_select && (interval == SHUFFLE_CYCLES - 28'h1);
	assign step_ofs     = (lfsr % `STEP_SPAN) + 8'h01;
	assign map_sum      = {1'b0, map_idx} + step_ofs[3:0];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lfsr <= `LFSR_SEED;
		end else begin
			lfsr <= lfsr[0] ? ((lfsr >> 1) ^ `LFSR_TAPS) : (lfsr >> 1);
		end
	end

	// The step is never zero, so every tick gives a different mapping.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			interval <= '0;
			map_idx  <= `MAP_IDENTITY;
		end else if (!band_shuffle_enable) begin
			interval <= '0;
			map_idx  <= `MAP_IDENTITY;
		end else if (pattern_select) begin
			interval <= '0;
		end else if (shuffle_tick) begin
			interval <= '0;
			map_idx  <= (map_sum >= `MAP_COUNT) ? 3'(map_sum - `MAP_COUNT) : map_sum[2:0];
		end else begin
			interval <= interval + 28'h1;
		end
	end

	// ==========================================================
	// Duty selection per output
	pwm_if pwm ();
	led_pwm_pkg::duty_t [2:0] band_duty;
	assign band_duty = {{1'b0, level_high}, {1'b0, level_mid}, {1'b0, level_low}};
	assign pwm.rate  = ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO];

	for (genvar k = 0; k < `BAND_COUNT; k++) begin : g_out
		logic [2:0] band;
		assign band = (map_idx < `MAP_MIRROR) ? 3'((map_idx + 3'(k)) % 3'(`BAND_COUNT))
		                                      : 3'((map_idx - 3'(k)) % 3'(`BAND_COUNT));
		always_comb begin
			if (pattern_select) begin
				pwm.duty[k] = force_out[k] ? `DUTY_FULL : 9'h000;
			end else begin
				pwm.duty[k] = band_duty[band[1:0]];
			end
		end
	end

	pwm_core #(
		.DIV_F0 (16'(`PWM_DIV(`PWM_F0_HZ))),
		.DIV_F1 (PWM_DIV_F1),
		.DIV_F2 (PWM_DIV_F2),
		.DIV_F3 (PWM_DIV_F3)
	) u_pwm (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pwm     (pwm.core),
		.led_out (led_out)
	);

	// ==========================================================
	// Register port read
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd && reg_addr == `REG_CTRL) begin
			reg_rdata <= ctrl;
		end else if (reg_rd && reg_addr == `REG_STATUS) begin
			reg_rdata <= {4'h0, state != led_pwm_pkg::st_idle, map_idx};
		end else begin
			reg_rdata <= '0;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_addr_match: assert property ((state == led_pwm_pkg::st_addr) && scl_rise && (bit_cnt == `BIT_LAST)
		&& !start_det && !stop_det |=> (state == led_pwm_pkg::st_addr_ack) == ($past(next_byte) == $past(own_addr)))
		else $error("address compare wrong");
	a_bit_sample: assert property ((state == led_pwm_pkg::st_data) && scl_rise && !start_det && !stop_det
		|=> shift[0] == $past(sda_s) && bit_cnt == $past(bit_cnt) + 3'h1)
		else $error("bit not taken on rising clock");
	a_start_enter: assert property (start_det |=> state == led_pwm_pkg::st_addr && bit_cnt == 3'h0)
		else $error("start did not begin address phase");
	a_ack_only: assert property (!sda_oe_n |-> !sda_out && (state == led_pwm_pkg::st_addr_ack
		|| state == led_pwm_pkg::st_data_ack))
		else $error("data line driven outside acknowledge");
	a_ack_window: assert property ($fell(sda_oe_n) |-> !scl_s ##1 !sda_oe_n [*2])
		else $error("acknowledge drive too short");
	a_stop_idle: assert property (stop_det && !start_det |=> state == led_pwm_pkg::st_idle && sda_oe_n)
		else $error("stop did not free the bus");
	a_map_identity: assert property (!band_shuffle_enable ##1 !band_shuffle_enable |-> map_idx == `MAP_IDENTITY)
		else $error("mapping not identity with shuffle off");
	a_pattern_hold: assert property ($past(pattern_select) && $past(band_shuffle_enable) |-> $stable(map_idx))
		else $error("mapping moved in pattern mode");
	a_shuffle_new: assert property (shuffle_tick |=> map_idx != $past(map_idx) && interval == 28'h0)
		else $error("shuffle tick gave no new mapping");
	a_audio_duty: assert property (!pattern_select && map_idx == `MAP_IDENTITY
		|-> pwm.duty[0] == {1'b0, level_low} && pwm.duty[2] == {1'b0, level_high})
		else $error("band to output mapping wrong");
endmodule

// *** i2c_host_model.sv ***
// Two-wire bus controller model that drives the target's serial pins
`timescale 1ns/1ns
module i2c_host_model (
	// Bus pins
	output logic     scl,
	output logic     sda_rel,
	input  wire logic sda
);
	// ==========================================================
	// Bit timing: 160 ns per bit, 80 ns high, clock still between frames
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic start;
		sda_rel = 1'b1;
		#80 scl = 1'b1;
		#40 sda_rel = 1'b0;
		#40 scl = 1'b0;
	endtask
	task automatic stop;
		#40 sda_rel = 1'b0;
		#40 scl = 1'b1;
		#40 sda_rel = 1'b1;
	endtask
	// Ack sampled late in the high phase, since the target answers through a synchroniser
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#40 sda_rel = b[i];
			#40 scl = 1'b1;
			#80 scl = 1'b0;
		end
		#40 sda_rel = 1'b1;
		#40 scl = 1'b1;
		#80 ack = ~sda;
		scl = 1'b0;
	endtask
endmodule

// *** led_pwm_consts.svh ***
// Shared constants for the audio synchronised LED PWM controller
`ifndef LED_PWM_CONSTS_SVH
`define LED_PWM_CONSTS_SVH

// ==========================================================
// Clock and timing
`define CLK_HZ          50000000
`define PWM_STEPS       256
`define PWM_F0_HZ       15000
`define PWM_F1_HZ       60
`define PWM_F2_HZ       7
`define PWM_F3_HZ       4
`define PWM_DIV(hz)     ((`CLK_HZ) / ((hz) * `PWM_STEPS))
`define SHUFFLE_MS      3200
`define SHUFFLE_CYCLES  ((`SHUFFLE_MS) * ((`CLK_HZ) / 1000))

// ==========================================================
// Target address, upper six bits and write direction
`define TARGET_ADDR_HI  6'h3D
`define TARGET_WRITE    1'h0
`define BIT_LAST        3'h7

// ==========================================================
// Register indices and control field layout
`define REG_CTRL        8'h00
`define REG_STATUS      8'h01
`define CTRL_RESET      8'h00
`define CTRL_PATTERN    0
`define CTRL_SHUFFLE    1
`define CTRL_RATE_LO    2
`define CTRL_RATE_HI    3
`define CTRL_FORCE_LO   4
`define CTRL_FORCE_HI   6

// ==========================================================
// Duty, mapping and randomiser
`define DUTY_FULL       9'h100
`define MAP_IDENTITY    3'h0
`define MAP_COUNT       4'h6
`define MAP_MIRROR      3'h3
`define BAND_COUNT      3
`define LFSR_SEED       8'h01
`define LFSR_TAPS       8'hB8
`define STEP_SPAN       8'h05

`endif

// *** led_pwm_pkg.sv ***
// Types shared by the LED PWM controller modules
package led_pwm_pkg;
	typedef enum logic [4:0] {
		st_idle     = 5'b00001,
		st_addr     = 5'b00010,
		st_addr_ack = 5'b00100,
		st_data     = 5'b01000,
		st_data_ack = 5'b10000
	} i2c_state_t;
	typedef logic [8:0] duty_t;
	typedef logic [1:0] pwm_rate_t;
	typedef logic [2:0] map_idx_t;
endpackage

// *** pwm_core.sv ***
// Three channel PWM counter with four selectable rates
`timescale 1ns/1ns
`include "led_pwm_consts.svh"
module pwm_core #(
	parameter logic [15:0] DIV_F0 = 16'(`PWM_DIV(`PWM_F0_HZ)),
	parameter logic [15:0] DIV_F1 = 16'(`PWM_DIV(`PWM_F1_HZ)),
	parameter logic [15:0] DIV_F2 = 16'(`PWM_DIV(`PWM_F2_HZ)),
	parameter logic [15:0] DIV_F3 = 16'(`PWM_DIV(`PWM_F3_HZ))
) (
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst,
	// Duty and rate
	pwm_if.core        pwm,
	// LED drive
	output logic [2:0] led_out
);
	logic [15:0] prescale;
	logic [15:0] div_sel;
	logic [7:0]  step;

	// ==========================================================
	// Rate select
	always_comb begin
		unique case (pwm.rate)
			2'h0: div_sel = DIV_F0;
			2'h1: div_sel = DIV_F1;
			2'h2: div_sel = DIV_F2;
			2'h3: div_sel = DIV_F3;
		endcase
	end

	// ==========================================================
	// Period counter
	// A rate change that leaves the count past the new limit wraps at once rather than running on.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prescale <= '0;
			step     <= '0;
		end else if (prescale >= div_sel - 16'h0001) begin
			prescale <= '0;
			step     <= step + 8'h01;
		end else begin
			prescale <= prescale + 16'h0001;
		end
	end

	// ==========================================================
	// Comparators
	// Full code holds the output on for the whole period.
	for (genvar k = 0; k < `BAND_COUNT; k++) begin : g_chan
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				led_out[k] <= 1'b0;
			end else begin
				led_out[k] <= (pwm.duty[k] == `DUTY_FULL) || ({1'b0, step} < pwm.duty[k]);
			end
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_full_on_duty: assert property ((pwm.duty[0] == `DUTY_FULL) [*2] |-> led_out[0])
		else $error("full duty did not hold output on");
	a_zero_off_duty: assert property ((pwm.duty[1] == 9'h000) [*2] |-> !led_out[1])
		else $error("zero duty did not hold output off");
endmodule

// *** pwm_if.sv ***
// Duty and rate carrier between control logic and PWM core
`timescale 1ns/1ns
interface pwm_if;
	led_pwm_pkg::duty_t [2:0] duty;
	led_pwm_pkg::pwm_rate_t   rate;
	modport ctrl (output duty, output rate);
	modport core (input duty, input rate);
endinterface

// *** test_audio_sync_led_pwm_ctrl.sv ***
// Self-checking bench for the audio synchronised LED PWM controller
`timescale 1ns/1ns
module test_audio_sync_led_pwm_ctrl;
	// ==========================================================
	// Shortened counts and signals
	localparam int DIV[4] = '{13, 4, 6, 8};
	localparam int SHUF   = 3000;
	logic       ref_clk, rst, scl, sda_rel, sda_out, sda_oe_n, addr_sel, reg_wr, reg_rd;
	logic [7:0] level_low, level_mid, level_high, reg_addr, reg_wdata, reg_rdata;
	logic [2:0] led_out;
	wire        sda_line;
	int         n_mismatch, cmp_count, cyc;
	int         lvl[3];
	// Pull-up wins unless someone pulls low
	assign sda_line = sda_rel & (sda_oe_n | sda_out);
	audio_sync_led_pwm_ctrl #(.PWM_DIV_F1(16'h0004), .PWM_DIV_F2(16'h0006), .PWM_DIV_F3(16'h0008),
		.SHUFFLE_CYCLES(28'h0000BB8)) i_audio_sync_led_pwm_ctrl (.ref_clk(ref_clk), .rst(rst),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
		.level_low(level_low), .level_mid(level_mid), .level_high(level_high), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .led_out(led_out));
	i2c_host_model i_i2c_host_model (.scl(scl), .sda_rel(sda_rel), .sda(sda_line));
	// ==========================================================
	// Clock, timeout and shared tasks
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		cmp(16'(d), 16'(exp));
	endtask
	task automatic frame(input logic [7:0] q[$], input logic exp_ack);
		logic ack;
		@(negedge ref_clk);
		i_i2c_host_model.start();
		foreach (q[i]) begin
			i_i2c_host_model.send_byte(q[i], ack);
			cmp(16'(ack), 16'(exp_ack));
			if (ack !== 1'b1) break;
		end
		i_i2c_host_model.stop();
	endtask
	// High cycles of each output over n cycles
	task automatic count(input int n, output int c[3]);
		c = '{0, 0, 0};
		repeat (n) begin
			@(negedge ref_clk);
			for (int k = 0; k < 3; k++) c[k] += int'(led_out[k] === 1'b1);
		end
	endtask
	function automatic int band(input int m, input int k);
		return (m < 3) ? (k + m) % 3 : (m - k) % 3;
	endfunction
	task automatic chk_duty(input int r, input int m);
		int c[3];
		count(DIV[r] * 256, c);
		for (int k = 0; k < 3; k++) cmp(16'(c[k]), 16'(lvl[band(m, k)] * DIV[r]));
	endtask
	task automatic set_levels(input int a, input int b, input int c);
		@(posedge ref_clk);
		level_low <= 8'(a);
		level_mid <= 8'(b);
		level_high <= 8'(c);
		lvl = '{a, b, c};
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		cmp(16'({sda_oe_n, led_out}), 16'h0008);
		rdc(8'h00, 8'h00);
		wr(8'h01, 8'hFF);
		wr(8'h20, 8'hFF);
		rdc(8'h01, 8'h00);
		rdc(8'h20, 8'h00);
	endtask
	task automatic t_bus;
		i_i2c_host_model.start();
		rdc(8'h01, 8'h08);
		i_i2c_host_model.stop();
		frame('{8'hF4, 8'h00, 8'h5A}, 1'b1);
		rdc(8'h00, 8'h5A);
		@(posedge ref_clk);
		addr_sel <= 1'b1;
		frame('{8'hF4}, 1'b0);
		frame('{8'hF7}, 1'b0);
		frame('{8'hF6, 8'h00, 8'h04, 8'h33}, 1'b1);
		rdc(8'h00, 8'h04);
		rdc(8'h01, 8'h00);
	endtask
	task automatic t_rate(input int r);
		wr(8'h00, {4'h0, 2'(r), 2'b00});
		repeat (DIV[r] * 256) @(posedge ref_clk);
		chk_duty(r, 0);
	endtask
	task automatic t_shuffle;
		logic [7:0] d;
		logic [7:0] e;
		int t0;
		wr(8'h00, 8'h06);
		d = 8'h00;
		for (int i = 0; i < 2000 && d[2:0] == 3'h0; i++) rd(8'h01, d);
		t0 = cyc;
		cmp(16'(d[2:0] != 3'h0 && d[2:0] < 3'h6), 16'h0001);
		chk_duty(1, int'(d[2:0]));
		e = d;
		for (int i = 0; i < 2000 && e[2:0] == d[2:0]; i++) rd(8'h01, e);
		cmp(16'(cyc - t0 >= SHUF - 2 && cyc - t0 <= SHUF + 2), 16'h0001);
		wr(8'h00, 8'h04);
		rdc(8'h01, 8'h00);
	endtask
	task automatic t_direct;
		int c[3];
		for (int f = 0; f < 8; f++) begin
			wr(8'h00, {1'b0, 3'(f), 4'b0111});
			repeat (4) @(posedge ref_clk);
			count(1024, c);
			for (int k = 0; k < 3; k++) cmp(16'(c[k]), f[k] ? 16'h0400 : 16'h0000);
		end
		rdc(8'h01, 8'h00);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		{addr_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{level_low, level_mid, level_high} = '0;
		{n_mismatch, cmp_count, cyc} = '0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		t_regs();
		t_bus();
		set_levels(48, 128, 200);
		for (int r = 0; r < 4; r++) t_rate(r);
		set_levels(0, 255, 1);
		t_rate(1);
		set_levels(40, 100, 210);
		t_shuffle();
		t_direct();
		test_done();
	end
endmodule
